// File: dv/bdr_diag_bank_tb.sv
`timescale 1ns/1ns
module bdr_diag_bank_tb;
  import bdr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  bdr_req_type req = '0;
  bdr_live_type live = '0;
  bdr_detect_type det = '0;
  logic det_valid = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic rhit;
  int fail_count = 0;
  int checked = 0;
  // ----------------------------------------
  // clock and device
  // ----------------------------------------
  always #5 clock = ~clock;
  bdr_diag_bank dut_u (.clock(clock), .rst_n(rst_n), .req(req), .live_in(live), .det_in(det),
    .det_valid(det_valid), .rdata(rdata), .rvalid(rvalid), .rhit(rhit));
  // ----------------------------------------
  // report and compare helpers
  // ----------------------------------------
  task automatic finish_test();
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic cmp_word(input logic [15:0] act, input logic [15:0] exp, input string what);
    checked++;
    if (act !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, act, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic act, input logic exp, input string what);
    checked++;
    if (act !== exp)
    begin
      fail_count++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, act, exp);
    end
  endtask : cmp_bit
  // one read strobe; answer is due right after the sampling edge, bounded wait for safety
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input logic hit);
    int k;
    @(posedge clock);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    k = 0;
    while (rvalid !== 1'b1 && k < 4)
    begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k == 4)
    begin
      fail_count++;
      $display("MISMATCH %0t no read answer", $time);
      finish_test();
    end
    else
    begin
      cmp_bit(k == 0, 1'b1, "latency");
      cmp_bit(rhit, hit, "hit");
      cmp_word(rdata, exp, "data");
      @(posedge clock);
      #1;
      cmp_bit(rvalid, 1'b0, "pulse");
      cmp_word(rdata, exp, "hold");
    end
  endtask : rd_chk
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 5; i++)
      rd_chk(8'h14 + 8'(2 * i), 16'h0000, 1'b1);
    rd_chk(8'h1e, 16'h0800, 1'b1);
    rd_chk(8'h20, 16'h0000, 1'b0);
  endtask : t_reset
  // other fields all ones so a leak into the reserved bits shows
  task automatic t_state();
    for (int i = 0; i < 20; i++)
    begin
      @(posedge clock);
      live <= '{i[4:0], 16'hffff, 16'hffff, 12'hfff, 11'h7ff};
      rd_chk(8'h14, {11'h000, i[4:0]}, 1'b1);
    end
  endtask : t_state
  // boost volts use a 100k over 10k divider: 1.89 mV per code step
  task automatic t_words();
    real mv;
    rd_chk(8'h16, 16'hffff, 1'b1);
    rd_chk(8'h1a, 16'h0fff, 1'b1);
    rd_chk(8'h1c, 16'h07ff, 1'b1);
    @(posedge clock);
    live <= '{5'h13, 16'ha5c3, 16'h3c5a, 12'h9e7, 11'h5b6};
    rd_chk(8'h16, 16'ha5c3, 1'b1);
    rd_chk(8'h18, 16'h3c5a, 1'b1);
    rd_chk(8'h1a, 16'h09e7, 1'b1);
    rd_chk(8'h1c, 16'h05b6, 1'b1);
    mv = BDR_BOOST_BASE_MV * (1.0 + 100000.0 / 10000.0) +
      real'(rdata[10:0]) * 100000.0 * BDR_BOOST_LSB_NA * 1.0e-6;
    cmp_word(16'($rtoi(mv)), 16'h3ec9, "boost volts");
  endtask : t_words
  task automatic t_detect();
    logic [2:0] c;
    logic [2:0] g;
    for (int i = 0; i < 8; i++)
    begin
      c = i[2:0];
      g = (i < 5) ? c : 3'h4;
      @(posedge clock);
      det <= '{c, g, ~c, c};
      det_valid <= 1'b1;
      @(posedge clock);
      det_valid <= 1'b0;
      rd_chk(8'h1e, {1'b0, c, 1'b1, g, 2'b00, ~c, c}, 1'b1);
    end
  endtask : t_detect
  // writes of all ones everywhere, then the last values must still read back
  task automatic t_write();
    for (int i = 0; i < 7; i++)
    begin
      @(posedge clock);
      req <= '{rd: 1'b0, wr: 1'b1, addr: 8'h14 + 8'(2 * i), wdata: 16'hffff};
    end
    @(posedge clock);
    req.wr <= 1'b0;
    rd_chk(8'h1e, 16'h7c07, 1'b1);
    rd_chk(8'h18, 16'h3c5a, 1'b1);
    rd_chk(8'h14, 16'h0013, 1'b1);
  endtask : t_write
  // second reset in mid-run clears the latched detection result
  task automatic t_rereset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd_chk(8'h1e, 16'h0800, 1'b1);
  endtask : t_rereset
  initial
  begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_state();
    t_words();
    t_detect();
    t_write();
    t_rereset();
    finish_test();
  end
endmodule : bdr_diag_bank_tb

// File: hdl/bdr_diag_bank.sv
`timescale 1ns/1ns
// Function
// RULE1: live 5-bit control state in bits 4-0, bits 15-5 zero
// RULE2: state codes 0 disabled through 13h all-fault, 4h-Fh boost ramp
// RULE3: measured input duty shown as full 16-bit word
// RULE4: applied output duty shown as full 16-bit word
// RULE5: 12-bit sink dac code in bits 11-0, upper bits zero
// RULE6: 11-bit boost voltage code in bits 10-0, upper bits zero
// RULE7: boost volts = divider-scaled 1.21V plus code times R1 times 18.9nA
// RULE8: detected dimming frequency code in bits 14-12
// RULE9: detected string grouping code in bits 10-8, 0h..4h
// RULE10: bits 15,7,6 read zero, bit 11 reads one
// RULE11: detected boost frequency code in bits 5-3
// RULE12: detected dimming mode and address half in bits 2-0
// RULE13: all registers read-only, writes ignored
module bdr_diag_bank
  import bdr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire bdr_pkg::bdr_req_type req,
  input wire bdr_pkg::bdr_live_type live_in,
  input wire bdr_pkg::bdr_detect_type det_in,
  input wire logic det_valid,
  output logic [15:0] rdata,
  output logic rvalid,
  output logic rhit
);
  import bdr_pkg::*;

  // ------------------------------------------------------------
  // live sampling
  // ------------------------------------------------------------
  bdr_live_type live_r;
  bdr_detect_type det_r;
  logic [15:0] rdata_r;
  logic rvalid_r;
  logic rhit_r;
  logic [15:0] mux_word;
  logic mux_hit;
  // live values are re-registered every cycle so a read shows at most one cycle old state
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      live_r <= '0;
    else
      live_r <= live_in; // RULE1
  end

  // detection results latch when detection reports them; held otherwise
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      det_r <= '0;
    else if (det_valid)
      det_r <= det_in; // RULE8
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  bdr_word_mux u_mux (
    .addr(req.addr),
    .live(live_r),
    .det(det_r),
    .word(mux_word),
    .hit(mux_hit)
  );

  // writes have no path into any storage here, they are dropped
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rdata_r <= BDR_RESET_VALUE;
      rvalid_r <= 1'b0;
      rhit_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= req.rd; // RULE13
      rhit_r <= req.rd & mux_hit;
      if (req.rd)
        rdata_r <= mux_word;
    end
  end
  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign rhit = rhit_r;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_state_read;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_STATE) |=>
        (rdata[15:5] == 11'h000 && rdata[4:0] == $past(live_r.control_state_now));
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read wrong"); // RULE1
  property p_state_code;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_STATE && live_r.control_state_now == BDR_ST_NORMAL)
        |=> rdata == 16'h0010;
  endproperty
  a_state_code: assert property (p_state_code) else $error("normal code wrong"); // RULE2
  property p_in_duty;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_IN_DUTY) |=> rdata == $past(live_r.input_duty);
  endproperty
  a_in_duty: assert property (p_in_duty) else $error("input duty wrong"); // RULE3
  property p_out_duty;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_OUT_DUTY) |=> rdata == $past(live_r.output_duty);
  endproperty
  a_out_duty: assert property (p_out_duty) else $error("output duty wrong"); // RULE4
  property p_sink;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_SINK_CODE) |=>
        rdata == {4'h0, $past(live_r.sink_dac_code)};
  endproperty
  a_sink: assert property (p_sink) else $error("sink code wrong"); // RULE5
  property p_boost;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_BOOST_CODE) |=>
        rdata == {5'h00, $past(live_r.boost_voltage_code)};
  endproperty
  a_boost: assert property (p_boost) else $error("boost code wrong"); // RULE6
  property p_auto_fixed;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_AUTODET) |=>
        (rdata[15] == 1'b0 && rdata[11] == 1'b1 && rdata[7:6] == 2'b00);
  endproperty
  a_auto_fixed: assert property (p_auto_fixed) else $error("reserved bits wrong"); // RULE10
  property p_auto_fields;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && req.addr == BDR_OFF_AUTODET) |=>
        (rdata[14:12] == $past(det_r.detected_dim_frequency) &&
         rdata[10:8] == $past(det_r.detected_string_grouping) &&
         rdata[5:3] == $past(det_r.detected_boost_frequency) &&
         rdata[2:0] == $past(det_r.detected_dim_mode));
  endproperty
  a_auto_fields: assert property (p_auto_fields) else $error("detect fields wrong"); // RULE8
  property p_write_only;
    @(posedge clock) disable iff (!rst_n)
      (req.wr && !req.rd) |=> (!rvalid && $stable(rdata));
  endproperty
  a_write_only: assert property (p_write_only) else $error("write had effect"); // RULE13
  property p_det_hold;
    @(posedge clock) disable iff (!rst_n)
      !det_valid |=> $stable(det_r);
  endproperty
  a_det_hold: assert property (p_det_hold) else $error("detect changed"); // RULE8
  // ------------------------------------------------------------
  // per-field and contract checks
  // ------------------------------------------------------------
  // request decodes rebuilt from the offsets so the checks do not lean on the mux
  wire rd_auto = req.rd && (req.addr == BDR_OFF_AUTODET);
  wire rd_state = req.rd && (req.addr == BDR_OFF_STATE);
  wire rd_mapped = req.rd && (req.addr == BDR_OFF_STATE || req.addr == BDR_OFF_IN_DUTY ||
    req.addr == BDR_OFF_OUT_DUTY || req.addr == BDR_OFF_SINK_CODE ||
    req.addr == BDR_OFF_BOOST_CODE || req.addr == BDR_OFF_AUTODET);
  wire state_in_ramp = (live_r.control_state_now >= BDR_ST_BOOST_FIRST) &&
    (live_r.control_state_now <= BDR_ST_BOOST_LAST);
  // one check each for the grouping, boost frequency and dimming mode fields so a swapped field points at its own rule
  property p_group_field;
    @(posedge clock) disable iff (!rst_n)
      rd_auto |=> rdata[10:8] == $past(det_r.detected_string_grouping);
  endproperty
  a_group_field: assert property (p_group_field) else $error("grouping field wrong"); // RULE9
  property p_bfreq_field;
    @(posedge clock) disable iff (!rst_n)
      rd_auto |=> rdata[5:3] == $past(det_r.detected_boost_frequency);
  endproperty
  a_bfreq_field: assert property (p_bfreq_field) else $error("boost freq wrong"); // RULE11
  property p_mode_field;
    @(posedge clock) disable iff (!rst_n)
      rd_auto |=> rdata[2:0] == $past(det_r.detected_dim_mode);
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("dimming mode wrong"); // RULE12
  // live copy must track its source with exactly one stage of delay
  property p_live_follow;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> live_r == $past(live_in);
  endproperty
  a_live_follow: assert property (p_live_follow) else $error("live copy stale"); // RULE1
  property p_det_load;
    @(posedge clock) disable iff (!rst_n)
      det_valid |=> det_r == $past(det_in);
  endproperty
  a_det_load: assert property (p_det_load) else $error("detect not loaded"); // RULE8
  // the answer strobe is as wide as the read request and mirrors it one edge later
  property p_read_pulse;
    @(posedge clock) disable iff (!rst_n)
      1'b1 |=> rvalid == $past(req.rd);
  endproperty
  a_read_pulse: assert property (p_read_pulse) else $error("read strobe wrong"); // RULE13
  property p_rdata_hold;
    @(posedge clock) disable iff (!rst_n)
      !req.rd |=> $stable(rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved"); // RULE13
  // unmapped offsets must never leak a neighbour's word
  property p_miss_zero;
    @(posedge clock) disable iff (!rst_n)
      (req.rd && !rd_mapped) |=> (rdata == BDR_UNMAPPED_VALUE && !rhit);
  endproperty
  a_miss_zero: assert property (p_miss_zero) else $error("unmapped read wrong"); // RULE13
  property p_hit_mapped;
    @(posedge clock) disable iff (!rst_n)
      rd_mapped |=> (rvalid && rhit);
  endproperty
  a_hit_mapped: assert property (p_hit_mapped) else $error("mapped read missed"); // RULE13
  // every ramp sub-state must read back inside the shared 4h-Fh band
  property p_state_ramp;
    @(posedge clock) disable iff (!rst_n)
      (rd_state && state_in_ramp) |=>
        (rdata >= {11'h000, BDR_ST_BOOST_FIRST} && rdata <= {11'h000, BDR_ST_BOOST_LAST});
  endproperty
  a_state_ramp: assert property (p_state_ramp) else $error("ramp state out of band"); // RULE2
  c_ramp_read: cover property (@(posedge clock) disable iff (!rst_n)
    rd_state && state_in_ramp);
  c_state_read: cover property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == BDR_OFF_STATE);
  c_auto_read: cover property (@(posedge clock) disable iff (!rst_n)
    req.rd && req.addr == BDR_OFF_AUTODET);
  c_write: cover property (@(posedge clock) disable iff (!rst_n) req.wr);
  c_miss: cover property (@(posedge clock) disable iff (!rst_n) rvalid && !rhit);
endmodule : bdr_diag_bank

// File: hdl/bdr_pkg.sv
package bdr_pkg;
  // ------------------------------------------------------------
  // register map (byte offsets of 16-bit registers)
  // ------------------------------------------------------------
  localparam logic [7:0] BDR_OFF_STATE = 8'h14;
  localparam logic [7:0] BDR_OFF_IN_DUTY = 8'h16;
  localparam logic [7:0] BDR_OFF_OUT_DUTY = 8'h18;
  localparam logic [7:0] BDR_OFF_SINK_CODE = 8'h1a;
  localparam logic [7:0] BDR_OFF_BOOST_CODE = 8'h1c;
  localparam logic [7:0] BDR_OFF_AUTODET = 8'h1e;
  localparam logic [15:0] BDR_RESET_VALUE = 16'h0000;
  localparam logic [15:0] BDR_UNMAPPED_VALUE = 16'h0000;
  // ------------------------------------------------------------
  // field widths and reserved constants
  // ------------------------------------------------------------
  localparam int BDR_STATE_W = 5;
  localparam int BDR_SINK_W = 12;
  localparam int BDR_BOOST_W = 11;
  localparam logic BDR_AUTODET_RSV11 = 1'b1;
  // boost code lsb weight in nA per ohm of top resistor, base in mV
  localparam real BDR_BOOST_LSB_NA = 18.9; // RULE7
  localparam real BDR_BOOST_BASE_MV = 1210.0; // RULE7
  // ------------------------------------------------------------
  // control state codes
  // ------------------------------------------------------------
  localparam logic [4:0] BDR_ST_DISABLED = 5'h00;
  localparam logic [4:0] BDR_ST_REG_START = 5'h01;
  localparam logic [4:0] BDR_ST_OTM_LOAD = 5'h02;
  localparam logic [4:0] BDR_ST_STANDBY = 5'h03;
  localparam logic [4:0] BDR_ST_BOOST_FIRST = 5'h04;
  localparam logic [4:0] BDR_ST_BOOST_LAST = 5'h0f;
  localparam logic [4:0] BDR_ST_NORMAL = 5'h10;
  localparam logic [4:0] BDR_ST_SHUTDOWN = 5'h11;
  localparam logic [4:0] BDR_ST_RETRY = 5'h12;
  localparam logic [4:0] BDR_ST_ALL_FAULT = 5'h13;
  localparam logic [2:0] BDR_GROUP_MAX = 3'h4;
  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [4:0] control_state_now;
    logic [15:0] input_duty;
    logic [15:0] output_duty;
    logic [11:0] sink_dac_code;
    logic [10:0] boost_voltage_code;
  } bdr_live_type;
  typedef struct packed {
    logic [2:0] detected_dim_frequency;
    logic [2:0] detected_string_grouping;
    logic [2:0] detected_boost_frequency;
    logic [2:0] detected_dim_mode;
  } bdr_detect_type;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } bdr_req_type;
endpackage : bdr_pkg

// File: hdl/bdr_word_mux.sv
`timescale 1ns/1ns
module bdr_word_mux
  import bdr_pkg::*;
(
  input wire logic [7:0] addr,
  input wire bdr_pkg::bdr_live_type live,
  input wire bdr_pkg::bdr_detect_type det,
  output logic [15:0] word,
  output logic hit
);
  // ------------------------------------------------------------
  // register word assembly
  // ------------------------------------------------------------
  // reserved fields are constants so they cannot be disturbed by writes
  wire [15:0] w_state = {11'h000, live.control_state_now}; // RULE1
  wire [15:0] w_sink = {4'h0, live.sink_dac_code}; // RULE5
  wire [15:0] w_boost = {5'h00, live.boost_voltage_code}; // RULE6
  wire [15:0] w_auto = {1'b0, det.detected_dim_frequency, BDR_AUTODET_RSV11, // RULE8 RULE10
    det.detected_string_grouping, 2'b00, det.detected_boost_frequency, // RULE9 RULE11
    det.detected_dim_mode}; // RULE12
  wire sel_state = (addr == BDR_OFF_STATE);
  wire sel_in = (addr == BDR_OFF_IN_DUTY);
  wire sel_out = (addr == BDR_OFF_OUT_DUTY);
  wire sel_sink = (addr == BDR_OFF_SINK_CODE);
  wire sel_boost = (addr == BDR_OFF_BOOST_CODE);
  wire sel_auto = (addr == BDR_OFF_AUTODET);
  assign hit = sel_state | sel_in | sel_out | sel_sink | sel_boost | sel_auto;
  assign word = sel_state ? w_state :
                sel_in ? live.input_duty : // RULE3
                sel_out ? live.output_duty : // RULE4
                sel_sink ? w_sink :
                sel_boost ? w_boost :
                sel_auto ? w_auto : BDR_UNMAPPED_VALUE;
endmodule : bdr_word_mux
